// [btt_trace_unit.sv]
// Debug trigger and eight-entry bus capture trace unit
`default_nettype none
`include "btt_consts.svh"
module btt_trace_unit #(
    parameter int DEPTH = `BTT_FIFO_DEPTH,
    parameter int AW    = `BTT_ADDR_WIDTH,
    parameter int DW    = `BTT_DATA_WIDTH
) (
    input  wire logic                        sys_clk,
    input  wire logic                        srst,
    input  wire logic                        clk_en,
    // CPU bus side
    input  wire logic [AW-1:0]               cpu_addr,
    input  wire logic [DW-1:0]               cpu_wdata,
    input  wire logic [DW-1:0]               cpu_rdata,
    input  wire logic                        cpu_rd,
    input  wire logic                        cpu_valid,
    input  wire logic                        cpu_opfetch,
    input  wire logic                        cpu_opexec,
    input  wire logic [AW-1:0]               cpu_exec_addr,
    input  wire logic                        cpu_cof,
    input  wire logic                        background_debug_controller_access,
    // Register port, shared by user map and background link
    input  wire logic                        reg_sel,
    input  wire logic                        reg_from_bdc,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    input  wire logic [AW-1:0]               reg_addr,
    input  wire logic [7:0]                  reg_wdata,
    output logic      [7:0]                  reg_rdata,
    output logic                             reg_hit,
    // Results
    output logic                             cpu_break,
    output logic      [`BTT_CNT_WIDTH-1:0]   fifo_word_count,
    output logic                             trace_armed
);
    import btt_pkg::*;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [7:0]             ctrl_r;
    logic [7:0]             trig_r;
    logic [AW-1:0]          cmpa_r;
    logic [AW-1:0]          cmpb_r;
    logic                   af_r;
    logic                   bf_r;
    logic [`BTT_FIFO_WIDTH-1:0] fifo_r [DEPTH];
    logic [`BTT_CNT_WIDTH-1:0]  cnt_r;
    logic [`BTT_CNT_WIDTH-1:0]  rd_ptr_r;
    logic [7:0]             fifo_lo_r;
    logic                   cof_on_r;
    btt_state_t             state_r;

    btt_mode_t  mode;
    logic       arm;
    logic       rw_qualify_enable_a;
    logic       rw_select_a;
    logic       in_hreg;
    logic [3:0] reg_idx;
    logic       wr_ctrl;

    assign mode    = btt_mode_t'(trig_r[`BTT_TRIG_MODE_HI:`BTT_TRIG_MODE_LO]);
    assign arm     = ctrl_r[`BTT_CTRL_ARM];
    assign rw_qualify_enable_a   = ctrl_r[`BTT_CTRL_RW_QUALIFY_ENABLE_A];
    assign rw_select_a     = ctrl_r[`BTT_CTRL_RWA];
    // Link accesses bypass the map window; user accesses decode high space
    assign in_hreg = reg_from_bdc
                  || (reg_addr >= `BTT_HREG_BASE
                      && reg_addr < `BTT_HREG_BASE + `BTT_HREG_SIZE);
    assign reg_idx = reg_addr[3:0];
    assign reg_hit = reg_sel && in_hreg;
    assign wr_ctrl = reg_hit && reg_wr && reg_idx == `BTT_REG_CTRL;

    // ----------------------------------------------------------------
    // Comparators
    // ----------------------------------------------------------------
    logic          data_mode;
    logic [AW-1:0] a_bus;
    logic [AW-1:0] b_bus;
    logic [DW-1:0] data_bus;
    logic          a_eq;
    logic          a_ge;
    logic          a_le;
    logic          b_eq;
    logic          b_ge;
    logic          b_le;

    assign data_mode = (mode == BTT_MODE_A_DATA) || (mode == BTT_MODE_A_STORE_DATA);
    // Write bus only when qualifier on and write selected
    assign data_bus  = (rw_qualify_enable_a && !rw_select_a) ? cpu_wdata : cpu_rdata;
    // Opcode tracking watches the executed address, not the fetch
    assign a_bus     = ctrl_r[`BTT_CTRL_TAG] ? cpu_exec_addr : cpu_addr;
    assign b_bus     = data_mode ? {{(AW-DW){1'b0}}, data_bus}
                                 : (ctrl_r[`BTT_CTRL_TAG] ? cpu_exec_addr : cpu_addr);

    btt_comparator #(.WIDTH(AW)) u_cmp_a (
        .ref_val     (cmpa_r),
        .bus_val     (a_bus),
        .bus_is_read (cpu_rd),
        .rw_qual_en  (rw_qualify_enable_a),
        .rw_sel      (rw_select_a),
        .equal_hit   (a_eq),
        .above_eq    (a_ge),
        .below_eq    (a_le)
    );

    btt_comparator #(.WIDTH(AW)) u_cmp_b (
        .ref_val     (data_mode ? {{(AW-DW){1'b0}}, cmpb_r[DW-1:0]} : cmpb_r),
        .bus_val     (b_bus),
        .bus_is_read (cpu_rd),
        .rw_qual_en  (ctrl_r[`BTT_CTRL_RWBEN]),
        .rw_sel      (ctrl_r[`BTT_CTRL_RWB]),
        .equal_hit   (b_eq),
        .above_eq    (b_ge),
        .below_eq    (b_le)
    );

    // ----------------------------------------------------------------
    // Match qualification
    // ----------------------------------------------------------------
    logic        cycle_ok;
    logic        match;
    btt_action_t action;

    // Fetches into the queue never trigger while tracking is on
    assign cycle_ok = !background_debug_controller_access
                   && (ctrl_r[`BTT_CTRL_TAG] ? cpu_opexec : cpu_valid);

    always_comb
    begin
        case (mode)
            BTT_MODE_A_ONLY:       match = a_eq;
            BTT_MODE_A_OR_B:       match = a_eq || b_eq;
            BTT_MODE_A_AND_B:      match = a_eq && b_eq;
            BTT_MODE_A_AND_NOT_B:  match = a_eq && !b_eq;
            BTT_MODE_A_DATA:       match = a_eq && b_eq;
            BTT_MODE_A_STORE_DATA: match = a_eq;
            BTT_MODE_INSIDE:       match = a_ge && b_le;
            BTT_MODE_OUTSIDE:      match = !(a_ge && b_le);
            default:               match = 1'b0;
        endcase
        match = match && cycle_ok;
    end

    // Action picked by break enable first, then by mode and begin/end option
    always_comb
    begin
        if (ctrl_r[`BTT_CTRL_BRKEN])
            action = BTT_ACT_BREAK;
        else if (mode == BTT_MODE_A_STORE_DATA)
            action = BTT_ACT_STORE_DATA;
        else if (trig_r[`BTT_TRIG_BEGIN])
            action = BTT_ACT_BEGIN_COF;
        else
            action = BTT_ACT_END_COF;
    end

    // ----------------------------------------------------------------
    // Store control
    // ----------------------------------------------------------------
    logic                       store_en;
    logic [`BTT_FIFO_WIDTH-1:0] store_word;
    logic                       full;
    logic                       halt_early;

    assign full       = cnt_r == `BTT_CNT_FULL;
    assign halt_early = wr_ctrl && arm && !reg_wdata[`BTT_CTRL_ARM] && !full;

    always_comb
    begin
        store_en   = 1'b0;
        store_word = '0;
        // A halt in the same cycle wins, so the count never runs ahead of the entries
        if (arm && !full && cycle_ok && !halt_early)
        begin
            case (action)
                BTT_ACT_STORE_DATA:
                begin
                    store_en   = match;
                    store_word = {{(`BTT_FIFO_WIDTH-DW){1'b0}}, data_bus};
                end
                BTT_ACT_BEGIN_COF, BTT_ACT_END_COF:
                begin
                    store_en   = cof_on_r && cpu_cof;
                    store_word = cpu_addr;
                end
                default:
                begin
                    store_en   = 1'b0;
                    store_word = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            cof_on_r <= 1'b0;
        else if (clk_en)
        begin
            if (!arm)
                cof_on_r <= 1'b0;
            else if (action == BTT_ACT_BEGIN_COF && match)
                cof_on_r <= 1'b1;
            else if (action == BTT_ACT_END_COF)
                // End-type trace records until the run is done; a match only blocks the following cycle
                cof_on_r <= !match && (state_r != BTT_ST_DONE);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            cpu_break <= 1'b0;
        else if (clk_en)
            cpu_break <= arm && action == BTT_ACT_BREAK && match;
    end

    // ----------------------------------------------------------------
    // Capture FIFO
    // ----------------------------------------------------------------
    logic rd_pop;

    assign rd_pop = reg_hit && reg_rd && reg_idx == `BTT_REG_FIFOL && rd_ptr_r != cnt_r;

    // Entry i takes the new word at slot cnt; a halt shifts every entry down one
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_fifo
        always_ff @(posedge sys_clk)
        begin
            if (srst)
                fifo_r[i] <= '0;
            else if (clk_en)
            begin
                if (halt_early)
                    fifo_r[i] <= (i < DEPTH - 1) ? fifo_r[(i + 1) % DEPTH] : '0;
                else if (store_en && cnt_r == `BTT_CNT_WIDTH'(i))
                    fifo_r[i] <= store_word;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            cnt_r <= '0;
        else if (clk_en)
        begin
            if (wr_ctrl && !arm && reg_wdata[`BTT_CTRL_ARM])
                cnt_r <= '0;
            else if (store_en)
                cnt_r <= cnt_r + `BTT_CNT_WIDTH'(1);
        end
    end

    // Readout in stored order; high byte first is latched for the low read
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            rd_ptr_r  <= '0;
            fifo_lo_r <= '0;
        end
        else if (clk_en)
        begin
            if (wr_ctrl && reg_wdata[`BTT_CTRL_ARM])
                rd_ptr_r <= '0;
            else if (rd_pop)
                rd_ptr_r <= rd_ptr_r + `BTT_CNT_WIDTH'(1);
            if (reg_hit && reg_rd && reg_idx == `BTT_REG_FIFOH)
                fifo_lo_r <= fifo_r[rd_ptr_r[2:0]][7:0];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            state_r <= BTT_ST_IDLE;
        else if (clk_en)
        begin
            case (state_r)
                BTT_ST_IDLE:  if (arm) state_r <= BTT_ST_WAIT;
                BTT_ST_WAIT:  if (!arm) state_r <= BTT_ST_DONE;
                              else if (store_en) state_r <= BTT_ST_STORE;
                BTT_ST_STORE: if (!arm || full) state_r <= BTT_ST_DONE;
                BTT_ST_DONE:  if (arm && wr_ctrl) state_r <= BTT_ST_WAIT;
                              else if (!arm) state_r <= BTT_ST_IDLE;
                default:      state_r <= BTT_ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register writes and flags
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            ctrl_r <= 8'h00;
            trig_r <= 8'h00;
            cmpa_r <= '0;
            cmpb_r <= '0;
        end
        else if (clk_en)
        begin
            if (reg_hit && reg_wr)
            begin
                case (reg_idx)
                    `BTT_REG_CTRL:  ctrl_r <= reg_wdata;
                    `BTT_REG_TRIG:  trig_r <= reg_wdata;
                    `BTT_REG_CMPAH: cmpa_r[15:8] <= reg_wdata;
                    `BTT_REG_CMPAL: cmpa_r[7:0] <= reg_wdata;
                    `BTT_REG_CMPBH: cmpb_r[15:8] <= reg_wdata;
                    `BTT_REG_CMPBL: cmpb_r[7:0] <= reg_wdata;
                    default:        ;
                endcase
            end
            // Trace run stops itself once the FIFO is full
            if (full && !(reg_hit && reg_wr && reg_idx == `BTT_REG_CTRL))
                ctrl_r[`BTT_CTRL_ARM] <= 1'b0;
        end
    end

    // Hit flags: set wins over the clear taken on arming
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            af_r <= 1'b0;
            bf_r <= 1'b0;
        end
        else if (clk_en)
        begin
            af_r <= (a_eq && cycle_ok) || (af_r && !(wr_ctrl && reg_wdata[`BTT_CTRL_ARM]));
            bf_r <= (b_eq && cycle_ok) || (bf_r && !(wr_ctrl && reg_wdata[`BTT_CTRL_ARM]));
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
            reg_rdata <= 8'h00;
        else if (clk_en)
        begin
            case (reg_idx)
                `BTT_REG_CTRL:  reg_rdata <= ctrl_r;
                `BTT_REG_TRIG:  reg_rdata <= trig_r;
                `BTT_REG_STAT:  reg_rdata <= {af_r, bf_r, arm, 1'b0, cnt_r};
                `BTT_REG_CMPAH: reg_rdata <= cmpa_r[15:8];
                `BTT_REG_CMPAL: reg_rdata <= cmpa_r[7:0];
                `BTT_REG_CMPBH: reg_rdata <= cmpb_r[15:8];
                `BTT_REG_CMPBL: reg_rdata <= cmpb_r[7:0];
                `BTT_REG_FIFOH: reg_rdata <= fifo_r[rd_ptr_r[2:0]][15:8];
                `BTT_REG_FIFOL: reg_rdata <= fifo_lo_r;
                default:        reg_rdata <= 8'h00;
            endcase
        end
    end

    assign fifo_word_count = cnt_r;
    assign trace_armed     = arm;
endmodule
`default_nettype wire

// [btt_consts.svh]
// Constant definitions for the bus trace trigger unit
`ifndef BTT_CONSTS_SVH
`define BTT_CONSTS_SVH

`define BTT_FIFO_DEPTH      8
`define BTT_FIFO_WIDTH      16
`define BTT_ADDR_WIDTH      16
`define BTT_DATA_WIDTH      8
`define BTT_CNT_WIDTH       4
`define BTT_CNT_FULL        4'h8
`define BTT_HREG_BASE       16'h1800
`define BTT_HREG_SIZE       16'h0010
`define BTT_REG_CTRL        4'h0
`define BTT_REG_TRIG        4'h1
`define BTT_REG_STAT        4'h2
`define BTT_REG_CMPAH       4'h3
`define BTT_REG_CMPAL       4'h4
`define BTT_REG_CMPBH       4'h5
`define BTT_REG_CMPBL       4'h6
`define BTT_REG_FIFOH       4'h7
`define BTT_REG_FIFOL       4'h8
`define BTT_CTRL_ARM        7
`define BTT_CTRL_BRKEN      6
`define BTT_CTRL_RW_QUALIFY_ENABLE_A      5
`define BTT_CTRL_RWA        4
`define BTT_CTRL_RWBEN      3
`define BTT_CTRL_RWB        2
`define BTT_CTRL_TAG        1
`define BTT_TRIG_BEGIN      7
`define BTT_TRIG_MODE_LO    0
`define BTT_TRIG_MODE_HI    3
`define BTT_STAT_AF         7
`define BTT_STAT_BF         6
`define BTT_STAT_ARMF       5

`endif

// [btt_pkg.sv]
// Types shared by the bus trace trigger unit
`default_nettype none
package btt_pkg;
    typedef enum logic [3:0] {
        BTT_MODE_A_ONLY,
        BTT_MODE_A_OR_B,
        BTT_MODE_A_AND_B,
        BTT_MODE_A_AND_NOT_B,
        BTT_MODE_A_DATA,
        BTT_MODE_A_STORE_DATA,
        BTT_MODE_INSIDE,
        BTT_MODE_OUTSIDE,
        BTT_MODE_RSVD8,
        BTT_MODE_RSVD9,
        BTT_MODE_RSVDA,
        BTT_MODE_RSVDB,
        BTT_MODE_RSVDC,
        BTT_MODE_RSVDD,
        BTT_MODE_RSVDE,
        BTT_MODE_RSVDF
    } btt_mode_t;

    typedef enum logic [1:0] {
        BTT_ACT_BREAK,
        BTT_ACT_STORE_DATA,
        BTT_ACT_BEGIN_COF,
        BTT_ACT_END_COF
    } btt_action_t;

    typedef enum {
        BTT_ST_IDLE,
        BTT_ST_WAIT,
        BTT_ST_STORE,
        BTT_ST_DONE
    } btt_state_t;
endpackage
`default_nettype wire

// [btt_comparator.sv]
// One sixteen-bit match and magnitude comparator with read/write qualifier
`default_nettype none
module btt_comparator #(
    parameter int WIDTH = 16
) (
    input  wire logic [WIDTH-1:0] ref_val,
    input  wire logic [WIDTH-1:0] bus_val,
    input  wire logic             bus_is_read,
    input  wire logic             rw_qual_en,
    input  wire logic             rw_sel,
    output logic                  equal_hit,
    output logic                  above_eq,
    output logic                  below_eq
);
    logic rw_ok;

    // Read/write qualifier may be ignored per comparator
    assign rw_ok     = !rw_qual_en || (bus_is_read == rw_sel);
    assign equal_hit = rw_ok && (bus_val == ref_val);
    // Magnitude terms for range modes
    assign above_eq  = rw_ok && (bus_val >= ref_val);
    assign below_eq  = rw_ok && (bus_val <= ref_val);
endmodule
`default_nettype wire

// [btt_trace_unit_checker.sv]
// Port-level assertions for the bus trace trigger unit
`default_nettype none
`include "btt_consts.svh"
module btt_trace_unit_checker (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        clk_en,
    input wire logic        background_debug_controller_access,
    input wire logic        reg_sel,
    input wire logic        reg_from_bdc,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_hit,
    input wire logic        cpu_break,
    input wire logic [3:0]  fifo_word_count,
    input wire logic        trace_armed
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    logic wr_any;
    logic ctl_wr;
    assign wr_any = clk_en && reg_sel && reg_wr;
    assign ctl_wr = wr_any && reg_hit && reg_addr[3:0] == `BTT_REG_CTRL;

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_count_max;
        fifo_word_count <= `BTT_CNT_FULL;
    endproperty
    a_count_max: assert property (p_count_max) else $error("count above depth");
    property p_full_disarm;
        $rose(fifo_word_count == `BTT_CNT_FULL) |-> ##[0:1] !trace_armed;
    endproperty
    a_full_disarm: assert property (p_full_disarm) else $error("armed after full");
    property p_count_step;
        !wr_any |=> fifo_word_count - $past(fifo_word_count) inside {4'h0, 4'h1};
    endproperty
    a_count_step: assert property (p_count_step) else $error("count jumped");
    property p_unarmed_hold;
        !trace_armed && !wr_any |=> $stable(fifo_word_count);
    endproperty
    a_unarmed_hold: assert property (p_unarmed_hold) else $error("store while unarmed");
    property p_arm_clears;
        ctl_wr && reg_wdata[`BTT_CTRL_ARM] |=> fifo_word_count == 4'h0 && trace_armed;
    endproperty
    a_arm_clears: assert property (p_arm_clears) else $error("arming failed");
    property p_halt_keep;
        ctl_wr && !reg_wdata[`BTT_CTRL_ARM] && trace_armed |=> $stable(fifo_word_count)
            && !trace_armed;
    endproperty
    a_halt_keep: assert property (p_halt_keep) else $error("halt changed count");
    property p_bdc_quiet;
        background_debug_controller_access |=> !cpu_break;
    endproperty
    a_bdc_quiet: assert property (p_bdc_quiet) else $error("break during bdc");
    property p_unmapped;
        clk_en && reg_sel && reg_rd && reg_hit && reg_addr[3:0] == 4'hF |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_window;
        reg_sel && !reg_from_bdc && reg_addr[15:4] != 12'h180 |-> !reg_hit;
    endproperty
    a_window: assert property (p_window) else $error("hit outside window");
    property p_bdc_hit;
        reg_sel && reg_from_bdc |-> reg_hit;
    endproperty
    a_bdc_hit: assert property (p_bdc_hit) else $error("link access missed");
    c_full: cover property (fifo_word_count == `BTT_CNT_FULL);
    c_break: cover property (cpu_break);
    c_halt: cover property (ctl_wr && !reg_wdata[`BTT_CTRL_ARM] && trace_armed);
endmodule
bind btt_trace_unit btt_trace_unit_checker chk_u (.*);
`default_nettype wire

// [btt_cpu_model.sv]
// Behavioural CPU bus model driving the trace unit's bus inputs
`default_nettype none
module btt_cpu_model (
    input  wire logic        sys_clk,
    output var  logic [15:0] cpu_addr,
    output var  logic [7:0]  cpu_wdata,
    output var  logic [7:0]  cpu_rdata,
    output var  logic        cpu_rd,
    output var  logic        cpu_valid,
    output var  logic        cpu_opfetch,
    output var  logic        cpu_opexec,
    output var  logic [15:0] cpu_exec_addr,
    output var  logic        cpu_cof,
    output var  logic        bdc_acc
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        {cpu_addr, cpu_wdata, cpu_rdata, cpu_exec_addr} = '0;
        {cpu_rd, cpu_valid, cpu_opfetch, cpu_opexec, cpu_cof, bdc_acc} = '0;
    end
    // One bus cycle; data lines show inverted junk once released
    task automatic cyc(input logic [15:0] a, input logic [7:0] wd, input logic [7:0] rdd,
                       input logic rd, input logic bdc);
        @(negedge sys_clk);
        {cpu_addr, cpu_wdata, cpu_rdata, cpu_rd, cpu_valid, bdc_acc} = {a, wd, rdd, rd, 1'b1, bdc};
        @(negedge sys_clk);
        {cpu_valid, bdc_acc, cpu_wdata, cpu_rdata} = {2'b00, ~wd, ~rdd};
    endtask
    // Change of flow at address a, seen as a valid bus cycle
    task automatic cof(input logic [15:0] a);
        @(negedge sys_clk);
        {cpu_addr, cpu_valid, cpu_cof} = {a, 2'b11};
        @(negedge sys_clk);
        {cpu_valid, cpu_cof} = 2'b00;
    endtask
    // Opcode really executes at address a
    task automatic exec(input logic [15:0] a);
        @(negedge sys_clk);
        {cpu_opexec, cpu_exec_addr} = {1'b1, a};
        @(negedge sys_clk);
        {cpu_opexec, cpu_exec_addr} = {1'b0, ~a};
    endtask
endmodule
`default_nettype wire

// [btt_trace_unit_tb.sv]
// Self-checking testbench for the bus trace trigger unit
`default_nettype none
module btt_trace_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import btt_pkg::*;
    logic        sys_clk, srst, reg_sel, reg_from_bdc, reg_wr, reg_rd;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d, h;
    logic        reg_hit, cpu_break, trace_armed;
    logic [3:0]  fifo_word_count;
    logic [11:0] hi;
    wire  [15:0] cpu_addr, cpu_exec_addr;
    wire  [7:0]  cpu_wdata, cpu_rdata;
    wire         cpu_rd, cpu_valid, cpu_opfetch, cpu_opexec, cpu_cof, bdc_acc;
    int          failures, check_count, cyc_n;
    btt_mode_t   mt [8] = '{BTT_MODE_INSIDE, BTT_MODE_INSIDE, BTT_MODE_OUTSIDE,
                            BTT_MODE_OUTSIDE, BTT_MODE_A_OR_B, BTT_MODE_A_AND_B,
                            BTT_MODE_A_AND_NOT_B, BTT_MODE_A_DATA};
    logic [15:0] at [8] = '{16'h3008, 16'h4000, 16'h4000, 16'h3008, 16'h3010, 16'h3010,
                            16'h3000, 16'h3000};
    logic        bt [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

    btt_cpu_model cpu_u (.sys_clk(sys_clk), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_rdata(cpu_rdata), .cpu_rd(cpu_rd), .cpu_valid(cpu_valid), .cpu_opfetch(cpu_opfetch),
        .cpu_opexec(cpu_opexec), .cpu_exec_addr(cpu_exec_addr), .cpu_cof(cpu_cof),
        .bdc_acc(bdc_acc));
    btt_trace_unit dut_u (.sys_clk(sys_clk), .srst(srst), .clk_en(1'b1), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_rd(cpu_rd), .cpu_valid(cpu_valid),
        .cpu_opfetch(cpu_opfetch), .cpu_opexec(cpu_opexec), .cpu_exec_addr(cpu_exec_addr),
        .cpu_cof(cpu_cof), .background_debug_controller_access(bdc_acc), .reg_sel(reg_sel),
        .reg_from_bdc(reg_from_bdc), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .cpu_break(cpu_break),
        .fifo_word_count(fifo_word_count), .trace_armed(trace_armed));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic rw(input logic [3:0] i, input logic [7:0] v);
        @(negedge sys_clk);
        {reg_sel, reg_wr, reg_addr, reg_wdata} = {2'b11, hi, i, v};
        @(negedge sys_clk);
        {reg_sel, reg_wr} = 2'b00;
    endtask
    // Read data is registered, so it is taken one cycle after the strobe
    task automatic rr(input logic [3:0] i, output logic [7:0] v);
        @(negedge sys_clk);
        {reg_sel, reg_rd, reg_addr} = {2'b11, hi, i};
        @(negedge sys_clk);
        {reg_sel, reg_rd} = 2'b00;
        v = reg_rdata;
    endtask

    // ----------------------------------------
    // Clock, timeout and sequence
    // ----------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc_n++;
        if (cyc_n == 20000)
        begin
            failures++;
            give_verdict();
        end
    end
    initial
    begin
        {srst, reg_sel, reg_from_bdc, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        srst = 1'b1;
        hi = 12'h180;
        repeat (6) @(negedge sys_clk);
        srst = 1'b0;
        check(fifo_word_count, 16'h0000);
        rw(4'h1, {4'h0, BTT_MODE_A_STORE_DATA});
        rw(4'h3, 8'h12);
        rw(4'h4, 8'h34);
        rw(4'h0, 8'h80);
        check(trace_armed, 16'h0001);
        for (int i = 0; i < 8; i++)
        begin
            cpu_u.cyc(16'h1235, 8'h00, 8'h00, 1'b1, 1'b0);
            cpu_u.cyc(16'h1234, 8'h00, 8'h00, 1'b1, 1'b1);
            cpu_u.cyc(16'h1234, 8'hA0 + i[7:0], 8'h40 + i[7:0], 1'b1, 1'b0);
            check(fifo_word_count, i[15:0] + 16'h1);
        end
        cpu_u.cyc(16'h1234, 8'h00, 8'hEE, 1'b1, 1'b0);
        check(trace_armed, 16'h0000);
        check(fifo_word_count, 16'h0008);
        for (int i = 0; i < 8; i++)
        begin
            rr(4'h7, h);
            rr(4'h8, d);
            check({h, d}, {8'h00, 8'h40 + i[7:0]});
        end
        rw(4'h0, 8'hA0);
        cpu_u.cyc(16'h1234, 8'h5A, 8'h11, 1'b1, 1'b0);
        check(fifo_word_count, 16'h0000);
        cpu_u.cyc(16'h1234, 8'h5A, 8'h11, 1'b0, 1'b0);
        rr(4'h7, h);
        rr(4'h8, d);
        check({h, d}, 16'h005A);
        check(fifo_word_count, 16'h0001);
        rw(4'h0, 8'h20);
        check({trace_armed, fifo_word_count}, 16'h0001);
        rw(4'h1, {4'h0, BTT_MODE_A_ONLY});
        rw(4'h3, 8'h20);
        rw(4'h4, 8'h00);
        rw(4'h0, 8'hC0);
        cpu_u.cyc(16'h2000, 8'h00, 8'h00, 1'b1, 1'b0);
        check(cpu_break, 16'h0001);
        cpu_u.cyc(16'h2000, 8'h00, 8'h00, 1'b1, 1'b1);
        check(cpu_break, 16'h0000);
        rw(4'h3, 8'h30);
        rw(4'h5, 8'h30);
        rw(4'h6, 8'h10);
        for (int i = 0; i < 8; i++)
        begin
            rw(4'h1, {4'h0, mt[i]});
            cpu_u.cyc(at[i], 8'h00, 8'h10, 1'b1, 1'b0);
            check(cpu_break, {15'h0, bt[i]});
        end
        rw(4'h1, {4'h0, BTT_MODE_A_ONLY});
        rw(4'h3, 8'h20);
        rw(4'h0, 8'hC2);
        cpu_u.cyc(16'h2000, 8'h00, 8'h00, 1'b1, 1'b0);
        check(cpu_break, 16'h0000);
        cpu_u.exec(16'h2000);
        check(cpu_break, 16'h0001);
        rr(4'hF, d);
        check(d, 16'h0000);
        hi = 12'h200;
        @(negedge sys_clk);
        {reg_sel, reg_addr} = {1'b1, hi, 4'h0};
        #1 check(reg_hit, 16'h0000);
        reg_from_bdc = 1'b1;
        #1 check(reg_hit, 16'h0001);
        reg_sel = 1'b0;
        rr(4'h0, d);
        check(d, 16'h00C2);
        rw(4'h1, 8'h80);
        rw(4'h0, 8'h80);
        cpu_u.cyc(16'h2000, 8'h00, 8'h00, 1'b1, 1'b0);
        cpu_u.cof(16'h2345);
        check(fifo_word_count, 16'h0001);
        rr(4'h7, h);
        rr(4'h8, d);
        check({h, d}, 16'h2345);
        give_verdict();
    end
endmodule
`default_nettype wire
